// ### psl_led_driver.sv
`timescale 1ns/100ps
`include "psl_consts.svh"
// Behaviour
// - duplex led low for full duplex, high for half duplex.
// - half-duplex collision: duplex led low 80 ms, then high 80 ms minimum.
// - speed led low at 100 Mbps, high at 10 Mbps.
// - link/activity led low with link up, high when link failed.
// - with link, tx or rx activity pulses link/activity led high 80 ms.
// - after each pulse the led stays low at least 80 ms.
// - new pulse after the gap only if more activity was seen.
module psl_led_driver (
  input wire logic mclk,
  input wire logic resetn,
  input wire psl_pkg::psl_status_t status,
  output psl_pkg::psl_leds_t leds
);
  import psl_pkg::*;

  // --------------------------------
  // status decode
  // --------------------------------
  // speed and duplex pins are shown as given, even with the link down
  wire link_ok;
  wire full_pin;
  wire half_link;
  wire fast_link;
  logic col_req;
  logic act_req;

  assign link_ok = status.link_up;
  assign full_pin = status.full_duplex;
  assign half_link = link_ok && !full_pin;
  assign fast_link = status.speed_100;

  // collisions only count in half duplex
  always_comb begin
    col_req = 1'b0;
    if (half_link) begin
      col_req = status.collision;
    end
  end

  // activity without a link is ignored
  always_comb begin
    act_req = 1'b0;
    if (link_ok) begin
      act_req = status.activity;
    end
  end

  // --------------------------------
  // helpers
  // --------------------------------
  // one place owns the pin polarity: a low pin lights the lamp
  function automatic logic led_level(input logic lamp_on);
    if (lamp_on) begin
      led_level = `PSL_LED_ON;
    end else begin
      led_level = `PSL_LED_OFF;
    end
  endfunction : led_level

  // two-bit selector shared by both blinking lamp decoders
  function automatic logic [1:0] pair(input logic hi, input logic lo);
    pair = {hi, lo};
  endfunction : pair

  // --------------------------------
  // collision blink timer
  // --------------------------------
  // held idle outside half duplex, which also drops any collision
  // remembered from before a duplex change
  logic col_pulsing;

  psl_pulse_timer u_col (
    .mclk(mclk),
    .resetn(resetn),
    .enable(half_link),
    .trigger(col_req),
    .pulsing(col_pulsing)
  );

  // --------------------------------
  // activity blink timer
  // --------------------------------
  // activity during a pulse or gap is kept and replayed after the
  // gap; a burst of one cycle blinks only once, a longer one blinks again after the gap
  logic act_pulsing;

  psl_pulse_timer u_act (
    .mclk(mclk),
    .resetn(resetn),
    .enable(link_ok),
    .trigger(act_req),
    .pulsing(act_pulsing)
  );

  // --------------------------------
  // duplex lamp
  // --------------------------------
  logic [1:0] duplex_mode;
  logic duplex_lamp;

  assign duplex_mode = pair(full_pin, half_link);
  // the timer flag lags link loss by a cycle, so it is gated here
  always_comb begin
    duplex_lamp = 1'b0;
    unique case (duplex_mode)
      2'b10: begin
        duplex_lamp = 1'b1;
      end
      2'b01: begin
        duplex_lamp = col_pulsing;
      end
      2'b00: begin
        duplex_lamp = 1'b0;
      end
      default: begin
        duplex_lamp = 1'b0;
      end
    endcase
  end

  // --------------------------------
  // speed lamp
  // --------------------------------
  logic speed_lamp;

  always_comb begin
    speed_lamp = 1'b0;
    unique case (fast_link)
      1'b1: begin
        speed_lamp = 1'b1;
      end
      1'b0: begin
        speed_lamp = 1'b0;
      end
    endcase
  end

  // --------------------------------
  // link and activity lamp
  // --------------------------------
  logic [1:0] link_mode;
  logic link_lamp;

  assign link_mode = pair(link_ok, act_pulsing);
  // dark while a pulse runs; the timer clears itself on link loss
  always_comb begin
    link_lamp = 1'b0;
    unique case (link_mode)
      2'b10: begin
        link_lamp = 1'b1;
      end
      2'b11: begin
        link_lamp = 1'b0;
      end
      2'b01: begin
        link_lamp = 1'b0;
      end
      2'b00: begin
        link_lamp = 1'b0;
      end
    endcase
  end

  // --------------------------------
  // pin levels
  // --------------------------------
  psl_leds_t next_leds;

  assign next_leds.duplex_led = led_level(duplex_lamp);
  assign next_leds.speed_led = led_level(speed_lamp);
  assign next_leds.link_activity_led = led_level(link_lamp);

  // --------------------------------
  // output register
  // --------------------------------
  // pins come from flops so no decode glitch reaches a lamp
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      leds.duplex_led <= `PSL_LED_OFF;
      leds.speed_led <= `PSL_LED_OFF;
      leds.link_activity_led <= `PSL_LED_OFF;
    end else begin
      leds <= next_leds;
    end
  end
endmodule : psl_led_driver

// ### psl_consts.svh
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH
// --------------------------------
// clock and timing
// --------------------------------
`define PSL_CLK_HZ 50000000
`define PSL_PULSE_MS 80
`define PSL_PULSE_CYC ((`PSL_CLK_HZ / 1000) * `PSL_PULSE_MS)
`define PSL_CNT_W 22
// --------------------------------
// led levels, active low
// --------------------------------
`define PSL_LED_ON 1'b0
`define PSL_LED_OFF 1'b1
`endif

// ### psl_pkg.sv
`include "psl_consts.svh"
package psl_pkg;
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic collision;
    logic activity;
  } psl_status_t;
  typedef struct packed {
    logic duplex_led;
    logic speed_led;
    logic link_activity_led;
  } psl_leds_t;
  typedef enum logic [1:0] {
    PSL_IDLE,
    PSL_PULSE,
    PSL_GAP
  } psl_state_t;
endpackage : psl_pkg

// ### psl_pulse_timer.sv
`timescale 1ns/100ps
`include "psl_consts.svh"
// blink sequencer: pulse then enforced gap; count clears on each state change, free-runs in idle
module psl_pulse_timer (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic trigger,
  output logic pulsing
);
  import psl_pkg::*;
  localparam logic [`PSL_CNT_W-1:0] LAST = `PSL_CNT_W'(`PSL_PULSE_CYC - 1);
  psl_state_t state;
  psl_state_t next_state;
  logic [`PSL_CNT_W-1:0] count;
  logic pending;
  wire count_done = (count == LAST);
  wire start = enable && (trigger || pending);
  wire pulse_start = (next_state == PSL_PULSE) && (state != PSL_PULSE);
  always_comb begin
    next_state = state;
    unique case (state)
      PSL_IDLE: if (start) next_state = PSL_PULSE;
      PSL_PULSE: if (count_done) next_state = PSL_GAP;
      PSL_GAP: if (count_done) next_state = start ? PSL_PULSE : PSL_IDLE;
      default: next_state = PSL_IDLE;
    endcase
    if (!enable) next_state = PSL_IDLE;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= PSL_IDLE;
      count <= '0;
      pending <= 1'b0;
      pulsing <= 1'b0;
    end else begin
      state <= next_state;
      count <= (next_state != state) ? '0 : count + 1'b1;
      // a start uses up the request; only later activity repeats it
      pending <= enable && !pulse_start && (trigger || pending);
      pulsing <= (next_state == PSL_PULSE);
    end
  end
endmodule : psl_pulse_timer

// ### psl_led_model.sv
`timescale 1ns/100ps
// lamps on the three outputs, lit while the pin is low
module psl_led_model (
  input wire psl_pkg::psl_leds_t leds,
  output logic [2:0] lit
);
  assign lit = ~leds;
endmodule : psl_led_model

// ### psl_led_chk.sv
`timescale 1ns/100ps
module psl_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire psl_pkg::psl_status_t status,
  input wire psl_pkg::psl_leds_t leds
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  rst_a: assert property ($rose(resetn) |-> &leds) else $error("rst");
  spd_a: assert property ($past(resetn) |->
    leds.speed_led != $past(status.speed_100)) else $error("spd");
  dup_fd_a: assert property ($past(resetn) && $past(status.full_duplex)
    |-> !leds.duplex_led) else $error("fd");
  dup_hd_a: assert property ($past(resetn) &&
    !$past(status.link_up | status.full_duplex) |-> leds.duplex_led)
    else $error("hd");
  lnk_a: assert property ($past(resetn) && !$past(status.link_up)
    |-> leds.link_activity_led) else $error("lnk");
  act_a: assert property ($rose(leds.link_activity_led) &&
    $past(status.link_up) |=> leds.link_activity_led[*8]) else $error("act");
  col_a: assert property ($fell(leds.duplex_led) &&
    !$past(status.full_duplex) |=> !leds.duplex_led[*8]) else $error("col");
  gap_a: assert property ($fell(leds.link_activity_led) &&
    $past(status.link_up, 2) |=> !leds.link_activity_led[*8]) else $error("gap");
endmodule : psl_chk
bind psl_led_driver psl_chk i_chk (.mclk(mclk), .resetn(resetn),
  .status(status), .leds(leds));

// ### test_psl_led_driver.sv
`timescale 1ns/100ps
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, v); end end
module test_psl_led_driver;
  import psl_pkg::*;
  logic mclk = 0;
  logic resetn = 0;
  psl_status_t status = '0;
  psl_leds_t leds;
  logic [2:0] lit;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  psl_led_driver i_dut (.mclk(mclk), .resetn(resetn), .status(status),
    .leds(leds));
  psl_led_model i_led (.leds(leds), .lit(lit));
  initial forever #10 mclk = ~mclk;
  // inputs move 1 ns after the edge so sampling never races
  task automatic put(input logic [4:0] s, input int n);
    status = s;
    repeat (n) @(posedge mclk);
    #1;
  endtask : put
  task automatic t_static;
    for (int i = 0; i < 4; i++) begin
      put({1'b1, i[1], i[0], 2'b00}, 2);
      `CHK("lit", {i[0], i[1], 1'b1}, lit)
    end
    put(5'b00000, 2);
    `CHK("down", 3'b000, lit)
  endtask : t_static
  task automatic t_act;
    put(5'b10101, 1);
    put(5'b10100, 1);
    `CHK("act", 1'b0, lit[0])
    put(5'b10101, 50);
    put(5'b10100, 50);
    `CHK("hold", 1'b0, lit[0])
    put(5'b00000, 2);
    put(5'b10100, 2);
    `CHK("clr", 1'b1, lit[0])
  endtask : t_act
  task automatic t_col;
    put(5'b10010, 1);
    put(5'b10000, 100);
    `CHK("col", 1'b1, lit[2])
  endtask : t_col
  task automatic t_rst;
    resetn = 0;
    put(5'b10100, 2);
    `CHK("rst", 3'b000, lit)
    resetn = 1;
    put(5'b10100, 3);
    `CHK("rel", 3'b101, lit)
  endtask : t_rst
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 1000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    put(5'b00000, 3);
    resetn = 1;
    t_static();
    t_act();
    t_col();
    t_rst();
    tally_and_finish();
  end
endmodule : test_psl_led_driver
